// file: sysreg_pkg.sv
// Package with offsets, field positions, reset values, timing counts and carrier types for the system register group.
`default_nettype none
package sysreg_pkg;
    localparam logic [11:0] OFS_GENERAL_TIMER_COUNT = 12'h090;
    localparam logic [11:0] OFS_FREE_RUNNING_COUNT  = 12'h09C;
    localparam logic [11:0] OFS_SOFT_RESET_CONTROL  = 12'h1F8;
    localparam int unsigned BIT_DIGITAL_RESET  = 0;
    localparam int unsigned BIT_FIRST_PHY_RST  = 1;
    localparam int unsigned BIT_SECOND_PHY_RST = 2;
    localparam int unsigned BIT_VIRTUAL_PHY_RST = 3;
    localparam logic [15:0] TIMER_COUNT_RESET  = 16'hFFFF;
    localparam logic [15:0] TIMER_LOAD_RESET   = 16'hFFFF;
    localparam logic [31:0] FREE_RUN_RESET     = 32'h0000_0000;
    localparam logic [31:0] REG_ZERO           = 32'h0000_0000;
    // Clock rate and reset hold time; the hold count rounds up.
    localparam int unsigned CLK_HZ             = 25_000_000;
    localparam int unsigned PHY_HOLD_NS        = 102_000;
    localparam int unsigned PHY_HOLD_CYCLES    = (PHY_HOLD_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
    localparam int unsigned VPHY_HOLD_CYCLES   = 4;
    localparam int unsigned DIGITAL_HOLD_CYCLES = 4;
    localparam int unsigned FREE_RUN_CLEAR_NS  = 160;
    // Host register access request.
    typedef struct packed {
        logic        rd;
        logic        wr;
        logic [11:0] addr;
        logic [31:0] wdata;
        logic        from_loader;
    } reg_req_t;
    // Timer configuration coming from the configuration register outside.
    typedef struct packed {
        logic        enable;
        logic [15:0] preload;
    } timer_cfg_t;
endpackage
`default_nettype wire

// file: timer_count_and_reset_control.sv
// System register group: general timer count, free-running counter and soft reset control.
`default_nettype none
// Function
// - Timer count register returns timer value low half, upper zero, resets to all ones.
// - Enabled timer counts down starting from the configured preload value.
// - 32-bit free-running counter clears on reset, increments every clock.
// - Free-running counter wraps to zero silently and keeps counting.
// - Counter may read stale up to 160 ns after reset.
// - Writing one to virtual PHY reset bit resets it; bit self-clears after.
// - Writing one to a port PHY bit resets it for at least 102 us.
// - Port PHY reset bits clear when their PHY leaves reset.
// - Writes to a self-clearing reset bit are ignored while it is set.
// - Digital reset resets chip except PLL and all three PHYs.
// - After digital reset the configuration loader starts, leaving PHYs alone.
// - Digital reset returns control registers to defaults, survivors excepted.
// - Digital reset aborts any configuration loader command in progress.
// - Digital reset bit clears itself when the chip leaves reset.
// - Configuration loader cannot write any of the four reset bits.
// - Reset control register reads harmlessly while device is not ready.
// - Either 16-bit half of reset control register is readable alone.
module timer_count_and_reset_control #(
    parameter int unsigned PHY_HOLD = sysreg_pkg::PHY_HOLD_CYCLES
) (
    input  wire logic                    clk,
    input  wire logic                    reset_n,
    input  wire sysreg_pkg::reg_req_t    req,
    input  wire sysreg_pkg::timer_cfg_t  timer_cfg,
    output logic [31:0]                  rdata,
    output logic                         rvalid,
    output logic                         virtual_phy_reset,
    output logic                         first_port_phy_reset,
    output logic                         second_port_phy_reset,
    output logic                         digital_reset,
    output logic                         loader_start,
    output logic                         loader_abort
);
    localparam int unsigned CW = $clog2(PHY_HOLD + 1);

    logic [15:0]   timer_ff;
    logic [31:0]   free_run_ff;
    logic          vphy_ff;
    logic          phy1_ff;
    logic          phy2_ff;
    logic          dig_ff;
    logic [CW-1:0] phy1_cnt_ff;
    logic [CW-1:0] phy2_cnt_ff;
    logic [2:0]    vphy_cnt_ff;
    logic [2:0]    dig_cnt_ff;
    logic          dig_done_ff;
    logic          host_wr;
    logic          core_rst;

    // The loader never reaches the reset bits, so only host writes count.
    // loader writes blocked
    assign host_wr  = req.wr && !req.from_loader && (req.addr == sysreg_pkg::OFS_SOFT_RESET_CONTROL);
    assign core_rst = !reset_n || dig_ff;

    // General timer reloads while disabled and counts down while enabled.
    always_ff @(posedge clk) begin
        if (core_rst) begin
            timer_ff <= sysreg_pkg::TIMER_COUNT_RESET;
        end else if (!timer_cfg.enable) begin
            timer_ff <= timer_cfg.preload;
        end else begin
            timer_ff <= timer_ff - 16'h0001;
        end
    end

    // The free-running counter wraps without any flag; a digital reset clears it too.
    always_ff @(posedge clk) begin
        if (core_rst) begin
            free_run_ff <= sysreg_pkg::FREE_RUN_RESET;
        end else begin
            free_run_ff <= free_run_ff + 32'h0000_0001;
        end
    end

    // Port PHY resets run their hold counter from the setting write.
    // hold port PHY reset
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            phy1_ff     <= 1'b0;
            phy2_ff     <= 1'b0;
            phy1_cnt_ff <= '0;
            phy2_cnt_ff <= '0;
        end else begin
            if (!phy1_ff && host_wr && req.wdata[sysreg_pkg::BIT_FIRST_PHY_RST]) begin
                phy1_ff     <= 1'b1;
                phy1_cnt_ff <= '0;
            end else if (phy1_ff) begin
                phy1_cnt_ff <= phy1_cnt_ff + CW'(1);
                if (phy1_cnt_ff == CW'(PHY_HOLD - 1)) begin
                    phy1_ff <= 1'b0;
                end
            end
            if (!phy2_ff && host_wr && req.wdata[sysreg_pkg::BIT_SECOND_PHY_RST]) begin
                phy2_ff     <= 1'b1;
                phy2_cnt_ff <= '0;
            end else if (phy2_ff) begin
                phy2_cnt_ff <= phy2_cnt_ff + CW'(1);
                if (phy2_cnt_ff == CW'(PHY_HOLD - 1)) begin
                    phy2_ff <= 1'b0;
                end
            end
        end
    end

    // The virtual PHY gets a short reset pulse, then the bit clears itself.
    // virtual PHY reset
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            vphy_ff     <= 1'b0;
            vphy_cnt_ff <= 3'h0;
        end else if (!vphy_ff && host_wr && req.wdata[sysreg_pkg::BIT_VIRTUAL_PHY_RST]) begin
            vphy_ff     <= 1'b1;
            vphy_cnt_ff <= 3'h0;
        end else if (vphy_ff) begin
            vphy_cnt_ff <= vphy_cnt_ff + 3'h1;
            if (vphy_cnt_ff == 3'(sysreg_pkg::VPHY_HOLD_CYCLES - 1)) begin
                vphy_ff <= 1'b0;
            end
        end
    end

    // Digital reset lasts a fixed number of cycles, then starts the loader.
    // It survives its own reset, so it is held only by the chip reset.
    // digital bit self-clears
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            dig_ff      <= 1'b0;
            dig_cnt_ff  <= 3'h0;
            dig_done_ff <= 1'b0;
        end else begin
            dig_done_ff <= 1'b0;
            if (!dig_ff && host_wr && req.wdata[sysreg_pkg::BIT_DIGITAL_RESET]) begin
                dig_ff     <= 1'b1;
                dig_cnt_ff <= 3'h0;
            end else if (dig_ff) begin
                dig_cnt_ff <= dig_cnt_ff + 3'h1;
                if (dig_cnt_ff == 3'(sysreg_pkg::DIGITAL_HOLD_CYCLES - 1)) begin
                    dig_ff      <= 1'b0;
                    dig_done_ff <= 1'b1;
                end
            end
        end
    end

    // Side-effect outputs; the PHY resets are not driven by the digital reset.
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            virtual_phy_reset     <= 1'b0;
            first_port_phy_reset  <= 1'b0;
            second_port_phy_reset <= 1'b0;
            digital_reset         <= 1'b0;
            loader_start          <= 1'b0;
            loader_abort          <= 1'b0;
        end else begin
            virtual_phy_reset     <= vphy_ff;
            first_port_phy_reset  <= phy1_ff;
            second_port_phy_reset <= phy2_ff;
            digital_reset         <= dig_ff;
            loader_start          <= dig_done_ff;
            loader_abort          <= !dig_ff && host_wr && req.wdata[sysreg_pkg::BIT_DIGITAL_RESET];
        end
    end

    // Read port; the full word is returned so either half may be used alone.
    // reads always harmless
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            rdata  <= sysreg_pkg::REG_ZERO;
            rvalid <= 1'b0;
        end else begin
            rvalid <= req.rd;
            rdata  <= sysreg_pkg::REG_ZERO;
            if (req.rd) begin
                case (req.addr)
                    sysreg_pkg::OFS_GENERAL_TIMER_COUNT: rdata <= {16'h0000, timer_ff};
                    // may be stale right after reset
                    sysreg_pkg::OFS_FREE_RUNNING_COUNT:  rdata <= free_run_ff;
                    sysreg_pkg::OFS_SOFT_RESET_CONTROL:  rdata <= {28'h0000000, vphy_ff, phy2_ff, phy1_ff, dig_ff};
                    default:                             rdata <= sysreg_pkg::REG_ZERO;
                endcase
            end
        end
    end

    // Assertions; each one names the rule it guards in the label at the start of its first line.
    // The hold length is counted here on its own, so a wrong step in the design's counter still shows up.
    logic [CW-1:0] phy2_len_ff;

    always_ff @(posedge clk) begin
        if (!reset_n || !phy2_ff) begin
            phy2_len_ff <= '0;
        end else if (phy2_len_ff != CW'(PHY_HOLD)) begin
            phy2_len_ff <= phy2_len_ff + CW'(1);
        end
    end

    a_phy1_hold: assert property (@(posedge clk) disable iff (!reset_n)
        $rose(phy1_ff) |-> phy1_ff [*8])
        else $error("port PHY reset released too early");

    a_phy2_length: assert property (@(posedge clk) disable iff (!reset_n)
        $fell(phy2_ff) |-> phy2_len_ff == CW'(PHY_HOLD))
        else $error("port PHY reset hold length wrong");

    a_phy_clears: assert property (@(posedge clk) disable iff (!reset_n)
        (phy1_ff && phy1_cnt_ff == CW'(PHY_HOLD - 1)) |=> !phy1_ff)
        else $error("port PHY bit did not clear");

    a_phy1_refuse: assert property (@(posedge clk) disable iff (!reset_n)
        (phy1_ff && host_wr) |=> phy1_cnt_ff == $past(phy1_cnt_ff) + CW'(1))
        else $error("write to a set port PHY bit restarted the hold");

    a_dig_refuse: assert property (@(posedge clk) disable iff (!reset_n)
        (dig_ff && host_wr) |=> dig_cnt_ff == $past(dig_cnt_ff) + 3'h1)
        else $error("write to a set digital bit restarted the reset");

    a_loader_block: assert property (@(posedge clk) disable iff (!reset_n)
        (req.wr && req.from_loader && !dig_ff) |=> !$rose(dig_ff))
        else $error("loader set reset bit");

    a_free_inc: assert property (@(posedge clk) disable iff (!reset_n)
        !$past(core_rst) |-> free_run_ff == $past(free_run_ff) + 32'h0000_0001)
        else $error("free counter skipped");

    a_free_clear: assert property (@(posedge clk) disable iff (!reset_n)
        $past(core_rst) |-> free_run_ff == sysreg_pkg::FREE_RUN_RESET)
        else $error("free counter not cleared");

    a_dig_clear: assert property (@(posedge clk) disable iff (!reset_n)
        $rose(dig_ff) |-> ##4 !dig_ff ##1 loader_start)
        else $error("digital reset not ended");

    a_abort_reset: assert property (@(posedge clk) disable iff (!reset_n)
        loader_abort |=> digital_reset)
        else $error("loader abort without digital reset");

    a_vphy_clear: assert property (@(posedge clk) disable iff (!reset_n)
        $rose(vphy_ff) |-> ##[1:5] !vphy_ff)
        else $error("virtual PHY bit stuck");

    a_timer_reset: assert property (@(posedge clk)
        !reset_n |=> timer_ff == sysreg_pkg::TIMER_COUNT_RESET)
        else $error("timer reset value wrong");

    a_timer_upper: assert property (@(posedge clk) disable iff (!reset_n)
        (rvalid && $past(req.addr) == sysreg_pkg::OFS_GENERAL_TIMER_COUNT) |-> rdata[31:16] == 16'h0000)
        else $error("timer count upper half not zero");

    a_timer_down: assert property (@(posedge clk) disable iff (!reset_n)
        ($past(timer_cfg.enable) && !$past(core_rst)) |-> timer_ff == $past(timer_ff) - 16'h0001)
        else $error("timer did not step down");

    a_timer_load: assert property (@(posedge clk) disable iff (!reset_n)
        (!$past(timer_cfg.enable) && !$past(core_rst)) |-> timer_ff == $past(timer_cfg.preload))
        else $error("timer did not take preload");

    a_phy_iso: assert property (@(posedge clk) disable iff (!reset_n)
        (dig_ff && !phy1_ff) |=> !first_port_phy_reset)
        else $error("digital reset hit PHY");

    a_read_answer: assert property (@(posedge clk) disable iff (!reset_n)
        req.rd |=> rvalid)
        else $error("read not answered");

    a_ctrl_reserved: assert property (@(posedge clk) disable iff (!reset_n)
        (rvalid && $past(req.addr) == sysreg_pkg::OFS_SOFT_RESET_CONTROL) |-> rdata[31:4] == 28'h0000000)
        else $error("reset control reserved bits not zero");

    // Main scenarios: digital reset, both port resets, virtual reset and a refused write.
    c_dig: cover property (@(posedge clk) $rose(dig_ff) ##[1:8] loader_start);
    c_phy1: cover property (@(posedge clk) $fell(phy1_ff));
    c_phy2: cover property (@(posedge clk) $fell(phy2_ff));
    c_vphy: cover property (@(posedge clk) $fell(vphy_ff));
    c_refused: cover property (@(posedge clk) phy1_ff && host_wr);
endmodule
`default_nettype wire

// file: host_model.sv
// Host model that issues register reads and writes on the request port.
`default_nettype none
module host_model (
    input  wire logic                 clk,
    output var sysreg_pkg::reg_req_t  req,
    input  wire logic [31:0]          rdata,
    input  wire logic                 rvalid
);
    timeunit 1ns;
    timeprecision 1ns;
    // Idle bus from time zero so no strobe is seen before reset ends.
    initial req = '0;
    // loader writes flagged
    // A strobe rises after a falling edge and is held over exactly one rising edge.
    task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic ldr);
        @(negedge clk);
        req <= '{rd: 1'b0, wr: 1'b1, addr: a, wdata: d, from_loader: ldr};
        @(negedge clk);
        req <= '{rd: 1'b0, wr: 1'b0, addr: ~a, wdata: ~d, from_loader: 1'b0};
    endtask
    // whole word read
    // Data stays unknown when no answer arrives, so a lost read cannot pass.
    task automatic rd(input logic [11:0] a, output logic [31:0] d);
        d = 'x;
        @(negedge clk);
        req <= '{rd: 1'b1, wr: 1'b0, addr: a, wdata: 32'h0000_0000, from_loader: 1'b0};
        @(negedge clk);
        req.rd <= 1'b0;
        for (int i = 0; i < 3 && rvalid !== 1'b1; i++) @(negedge clk);
        if (rvalid === 1'b1) d = rdata;
    endtask
endmodule
`default_nettype wire

// file: timer_count_and_reset_control_bench.sv
// Self-checking bench for the timer count and soft reset register group.
`default_nettype none
module timer_count_and_reset_control_bench;
    timeunit 1ns;
    timeprecision 1ns;
    localparam int HOLD = 8;
    logic                   clk = 1'b0;
    logic                   reset_n = 1'b0;
    sysreg_pkg::reg_req_t   req;
    sysreg_pkg::timer_cfg_t timer_cfg = '{enable: 1'b0, preload: sysreg_pkg::TIMER_LOAD_RESET};
    logic [31:0]            rdata, d, e;
    logic                   rvalid, vphy, phy1, phy2, dig, ld_start, ld_abort;
    int                     error_cnt = 0, n_tests = 0, cyc = 0, t0, sel = 1, hi_n, ab_n, st_n, dg_n, bad_n;
    // Half period of 25 ns gives the 50 ns bench clock.
    always #25 clk = ~clk;
    timer_count_and_reset_control #(.PHY_HOLD(HOLD)) dut_u (.clk(clk), .reset_n(reset_n), .req(req),
        .timer_cfg(timer_cfg), .rdata(rdata), .rvalid(rvalid), .virtual_phy_reset(vphy),
        .first_port_phy_reset(phy1), .second_port_phy_reset(phy2), .digital_reset(dig),
        .loader_start(ld_start), .loader_abort(ld_abort));
    host_model host_u (.clk(clk), .req(req), .rdata(rdata), .rvalid(rvalid));
    // Pulse and level monitors, counted per edge so short pulses are never missed.
    always @(posedge clk) begin
        cyc++;
        hi_n += ((sel == 1 ? phy1 : sel == 2 ? phy2 : vphy) === 1'b1);
        ab_n += (ld_abort === 1'b1);
        st_n += (ld_start === 1'b1);
        dg_n += (dig === 1'b1);
        bad_n += (dig === 1'b1 && (phy1 | phy2 | vphy) !== 1'b0);
    end
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            error_cnt++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic print_verdict();
        $display("Comparisons %0d mismatches %0d", n_tests, error_cnt);
        if (error_cnt == 0 && n_tests > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    // A reset bit is set, a second setting write is tried while set, then release is checked.
    // The second write must not stretch the hold, so the pulse length is compared exactly.
    task automatic phy_case(input int b, input int hold);
        sel = b;
        hi_n = 0;
        host_u.wr(sysreg_pkg::OFS_SOFT_RESET_CONTROL, 32'h0000_0001 << b, 1'b0);
        host_u.wr(sysreg_pkg::OFS_SOFT_RESET_CONTROL, 32'h0000_0001 << b, 1'b0);
        if (hold > 6) begin
            host_u.rd(sysreg_pkg::OFS_SOFT_RESET_CONTROL, d);
            check("reset bit set", {31'h0, d[b]}, 32'h0000_0001);
        end
        repeat (hold + 6) @(negedge clk);
        check("hold length", hi_n, hold);
        host_u.rd(sysreg_pkg::OFS_SOFT_RESET_CONTROL, d);
        check("bit self clear", d, 32'h0000_0000);
        $display("Port reset test on bit %0d done", b);
    endtask
    // Watchdog sized well beyond the fewer than 120 cycles the tests need.
    initial begin
        #100_000;
        error_cnt++;
        print_verdict();
    end
    // Main sequence.
    initial begin
        repeat (6) @(negedge clk);
        reset_n = 1'b1;
        host_u.rd(sysreg_pkg::OFS_GENERAL_TIMER_COUNT, d);
        check("timer reset", d, {16'h0000, sysreg_pkg::TIMER_COUNT_RESET});
        timer_cfg.preload = 16'h0040;
        host_u.rd(sysreg_pkg::OFS_GENERAL_TIMER_COUNT, d);
        check("timer count", d, 32'h0000_0040);
        host_u.rd(12'h100, d);
        check("unmapped", d, 32'h0000_0000);
        timer_cfg.enable = 1'b1;
        t0 = cyc;
        host_u.rd(sysreg_pkg::OFS_GENERAL_TIMER_COUNT, e);
        host_u.rd(sysreg_pkg::OFS_GENERAL_TIMER_COUNT, d);
        // The enable is seen one edge before the first read is sampled, and the reads sample two edges apart.
        check("timer first step", e, 32'h0000_003F);
        check("timer step", e - d, 32'(cyc - t0) - 32'd2);
        check("timer upper half", {16'h0, d[31:16]}, 32'h0000_0000);
        host_u.rd(sysreg_pkg::OFS_FREE_RUNNING_COUNT, e);
        repeat (7) @(negedge clk);
        host_u.rd(sysreg_pkg::OFS_FREE_RUNNING_COUNT, d);
        // The two reads are sampled nine clock edges apart.
        check("free run step", d - e, 32'd9);
        $display("Counter tests done");
        phy_case(1, HOLD);
        phy_case(2, HOLD);
        phy_case(3, sysreg_pkg::VPHY_HOLD_CYCLES);
        host_u.wr(sysreg_pkg::OFS_SOFT_RESET_CONTROL, 32'h0000_000F, 1'b1);
        repeat (3) @(negedge clk);
        check("loader write", {28'h0, vphy, phy2, phy1, dig}, 32'h0000_0000);
        $display("Loader refusal test done");
        // digital reset, with a second setting write that must be ignored
        {ab_n, st_n, dg_n, bad_n} = '0;
        host_u.wr(sysreg_pkg::OFS_SOFT_RESET_CONTROL, 32'h0000_0001, 1'b0);
        host_u.wr(sysreg_pkg::OFS_SOFT_RESET_CONTROL, 32'h0000_0001, 1'b0);
        host_u.rd(sysreg_pkg::OFS_SOFT_RESET_CONTROL, d);
        check("poll in reset", {31'h0, ^d !== 1'bx}, 32'h0000_0001);
        for (int i = 0; i < 8 && d[0] !== 1'b0; i++) begin
            host_u.rd(sysreg_pkg::OFS_SOFT_RESET_CONTROL, d);
        end
        repeat (10) @(negedge clk);
        check("abort pulse", ab_n, 32'd1);
        check("loader start", st_n, 32'd1);
        check("digital hold", dg_n, sysreg_pkg::DIGITAL_HOLD_CYCLES);
        check("phys untouched", bad_n, 32'd0);
        host_u.rd(sysreg_pkg::OFS_SOFT_RESET_CONTROL, d);
        check("digital clear", d, 32'h0000_0000);
        host_u.rd(sysreg_pkg::OFS_FREE_RUNNING_COUNT, d);
        check("free run restart", {31'h0, d < 32'd24}, 32'h0000_0001);
        $display("Digital reset test done");
        print_verdict();
    end
endmodule
`default_nettype wire
